// ### hw/itc_pkg.sv
/*
 * Shared constants and types for the interrupt and timer control
 * instruction executor: bus offsets, field positions, reset values,
 * the instruction codes and the control register bank type.
 * Assumes a 32-bit Avalon-MM slave port with nibble-wide registers.
 */
package itc_pkg;

	// Register byte addresses on the slave port.
	localparam logic [3:0] ITC_ADR_EXEC = 4'h0;
	localparam logic [3:0] ITC_ADR_RESULT = 4'h4;
	localparam logic [3:0] ITC_ADR_STATUS = 4'h8;

	// Field positions in the execute word.
	localparam int ITC_OP_LSB = 0;
	localparam int ITC_ACC_LSB = 8;

	// Field positions in the result word.
	localparam int ITC_RES_LOAD = 4;
	localparam int ITC_RES_SKIP = 5;

	// Field positions in the status word.
	localparam int ITC_ST_IE = 0;
	localparam int ITC_ST_REQ0 = 1;
	localparam int ITC_ST_REQ1 = 2;
	localparam int ITC_ST_SKIP = 3;
	localparam int ITC_ST_PIN0 = 4;
	localparam int ITC_ST_PIN1 = 5;

	// Bit positions inside the control registers.
	localparam int ITC_GATE0_BIT = 0;
	localparam int ITC_GATE1_BIT = 1;
	localparam int ITC_POL_BIT = 2;

	// Indices of the control registers in the bank.
	localparam logic [2:0] ITC_IX_ICTL1 = 3'h0;
	localparam logic [2:0] ITC_IX_ICTL2 = 3'h1;
	localparam logic [2:0] ITC_IX_ICFG1 = 3'h2;
	localparam logic [2:0] ITC_IX_ICFG2 = 3'h3;
	localparam logic [2:0] ITC_IX_TCTL1 = 3'h4;
	localparam logic [2:0] ITC_IX_TCTL2 = 3'h5;
	localparam logic [2:0] ITC_IX_TCTL3 = 3'h6;
	localparam logic [2:0] ITC_IX_TCTL4 = 3'h7;

	// Reset value of every nibble register.
	localparam logic [3:0] ITC_NIB_RST = 4'h0;

	// Instruction codes accepted by the executor.
	typedef enum logic [4:0] {
		ITC_NO_OP = 5'h00, ITC_MASK_IRQ = 5'h01, ITC_UNMASK_IRQ = 5'h02,
		ITC_TEST_REQ0 = 5'h03, ITC_TEST_REQ1 = 5'h04, ITC_TEST_LVL0 = 5'h05, ITC_TEST_LVL1 = 5'h06,
		ITC_RD_ICTL1 = 5'h07, ITC_WR_ICTL1 = 5'h08, ITC_RD_ICTL2 = 5'h09, ITC_WR_ICTL2 = 5'h0A,
		ITC_RD_ICFG1 = 5'h0B, ITC_WR_ICFG1 = 5'h0C, ITC_RD_ICFG2 = 5'h0D, ITC_WR_ICFG2 = 5'h0E,
		ITC_WR_TSEL = 5'h0F,
		ITC_RD_TCTL1 = 5'h10, ITC_WR_TCTL1 = 5'h11, ITC_RD_TCTL2 = 5'h12, ITC_WR_TCTL2 = 5'h13,
		ITC_RD_TCTL3 = 5'h14, ITC_WR_TCTL3 = 5'h15, ITC_RD_TCTL4 = 5'h16, ITC_WR_TCTL4 = 5'h17
	} itc_op_t;

	// Eight nibble control registers, indexed by the ITC_IX constants.
	typedef logic [7:0][3:0] itc_bank_t;

endpackage

// ### hw/itc_exec.sv
/*
 * Executor for the interrupt and timer control instructions of a
 * small 4-bit core. Software issues one instruction per write to the
 * execute register, with the accumulator value beside the op code.
 * Assumes one 250 MHz clock, synchronous pins and request-set pulses.
 */
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module itc_exec
	import itc_pkg::*;
(
	input wire logic clk, // Core clock, 250 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [3:0] avs_address, // Byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Low for the answer cycle.
	input wire logic ext_irq_pin_zero, // External interrupt pin zero.
	input wire logic ext_irq_pin_one, // External interrupt pin one.
	input wire logic ext0_req_set, // Pulse: ext0 request event.
	input wire logic ext1_req_set, // Pulse: ext1 request event.
	output logic irq_global_enable, // Global interrupt enable.
	output logic ext0_req_flag, // External 0 request flag.
	output logic ext1_req_flag, // External 1 request flag.
	output itc_bank_t ctl_bank, // Interrupt and timer control registers.
	output logic timer_select_ctrl, // Timer select control bit.
	output logic [3:0] acc_value, // Value for the accumulator.
	output logic acc_load, // Pulse: load accumulator.
	output logic skip_next // Next instruction is to be skipped.
);

	// Reset release chain; only the second stage is used elsewhere.
	logic rst_meta;
	logic rst_sync_n;

	// Two flops release the reset cleanly on the clock.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Bus decode. A request is answered on the cycle after it rises.
	wire bus_req = avs_read | avs_write;
	wire bus_take = bus_req & avs_waitrequest;
	wire wr_take = bus_take & avs_write;
	wire rd_take = bus_take & avs_read;
	wire exec_fire = wr_take & (avs_address == ITC_ADR_EXEC);

	// The instruction and its accumulator operand.
	itc_op_t op;
	wire [3:0] acc_in = avs_writedata[ITC_ACC_LSB +: 4];
	assign op = itc_op_t'(avs_writedata[ITC_OP_LSB +: 5]);

	// A pending skip swallows the next instruction whole.
	wire live = exec_fire & ~skip_next;

	// Gate and polarity bits pulled from the bank.
	wire gate0 = ctl_bank[ITC_IX_ICTL1][ITC_GATE0_BIT];
	wire gate1 = ctl_bank[ITC_IX_ICTL1][ITC_GATE1_BIT];
	wire pol0 = ctl_bank[ITC_IX_ICFG1][ITC_POL_BIT];
	wire pol1 = ctl_bank[ITC_IX_ICFG2][ITC_POL_BIT];

	// Flag tests; a set gate turns the test into a no-operation.
	wire req0_hit = live & (op == ITC_TEST_REQ0) & ~gate0 & ext0_req_flag;
	wire req1_hit = live & (op == ITC_TEST_REQ1) & ~gate1 & ext1_req_flag;

	// Pin level tests compare the pin against its polarity bit.
	wire lvl0_hit = live & (op == ITC_TEST_LVL0) & (ext_irq_pin_zero == pol0);
	wire lvl1_hit = live & (op == ITC_TEST_LVL1) & (ext_irq_pin_one == pol1);
	wire skip_set = req0_hit | req1_hit | lvl0_hit | lvl1_hit;

	// Transfer decode: register index and direction.
	logic [2:0] bank_ix;
	logic is_rd;
	logic is_wr;

	// Maps every transfer op to its bank slot.
	always_comb
	begin
		bank_ix = ITC_IX_ICTL1;
		is_rd = 1'b0;
		is_wr = 1'b0;
		unique case (op)
			ITC_RD_ICTL1:
			begin
				bank_ix = ITC_IX_ICTL1;
				is_rd = 1'b1;
			end
			ITC_WR_ICTL1:
			begin
				bank_ix = ITC_IX_ICTL1;
				is_wr = 1'b1;
			end
			ITC_RD_ICTL2:
			begin
				bank_ix = ITC_IX_ICTL2;
				is_rd = 1'b1;
			end
			ITC_WR_ICTL2:
			begin
				bank_ix = ITC_IX_ICTL2;
				is_wr = 1'b1;
			end
			ITC_RD_ICFG1:
			begin
				bank_ix = ITC_IX_ICFG1;
				is_rd = 1'b1;
			end
			ITC_WR_ICFG1:
			begin
				bank_ix = ITC_IX_ICFG1;
				is_wr = 1'b1;
			end
			ITC_RD_ICFG2:
			begin
				bank_ix = ITC_IX_ICFG2;
				is_rd = 1'b1;
			end
			ITC_WR_ICFG2:
			begin
				bank_ix = ITC_IX_ICFG2;
				is_wr = 1'b1;
			end
			ITC_RD_TCTL1:
			begin
				bank_ix = ITC_IX_TCTL1;
				is_rd = 1'b1;
			end
			ITC_WR_TCTL1:
			begin
				bank_ix = ITC_IX_TCTL1;
				is_wr = 1'b1;
			end
			ITC_RD_TCTL2:
			begin
				bank_ix = ITC_IX_TCTL2;
				is_rd = 1'b1;
			end
			ITC_WR_TCTL2:
			begin
				bank_ix = ITC_IX_TCTL2;
				is_wr = 1'b1;
			end
			ITC_RD_TCTL3:
			begin
				bank_ix = ITC_IX_TCTL3;
				is_rd = 1'b1;
			end
			ITC_WR_TCTL3:
			begin
				bank_ix = ITC_IX_TCTL3;
				is_wr = 1'b1;
			end
			ITC_RD_TCTL4:
			begin
				bank_ix = ITC_IX_TCTL4;
				is_rd = 1'b1;
			end
			ITC_WR_TCTL4:
			begin
				bank_ix = ITC_IX_TCTL4;
				is_wr = 1'b1;
			end
			default: ; // Non-transfer ops and illegal codes move nothing.
		endcase
	end

	wire rd_go = live & is_rd;
	wire wr_go = live & is_wr;

	// Request flags: a hardware set beats a skip clear in the same cycle.
	wire next_req0 = ext0_req_set | (ext0_req_flag & ~req0_hit);
	wire next_req1 = ext1_req_set | (ext1_req_flag & ~req1_hit);

	// Enable flag follows the mask and unmask instructions.
	wire next_ie = (live & (op == ITC_UNMASK_IRQ)) ? 1'b1 :
		(live & (op == ITC_MASK_IRQ)) ? 1'b0 : irq_global_enable;

	// Skip flag: set by a test, cleared by the swallowed instruction.
	wire next_skip = skip_set | (skip_next & ~exec_fire);

	// Register reads return the latest result, the status word, or zero for any other address.
	wire [31:0] res_word = {26'h0, skip_next, acc_load, acc_value};
	wire [31:0] st_word = {26'h0, ext_irq_pin_one, ext_irq_pin_zero,
		skip_next, ext1_req_flag, ext0_req_flag, irq_global_enable};
	wire [31:0] rd_word = (avs_address == ITC_ADR_RESULT) ? res_word :
		(avs_address == ITC_ADR_STATUS) ? st_word : 32'h0;

	// Bus handshake: waitrequest drops for exactly one cycle per request.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end
		else
		begin
			avs_waitrequest <= ~bus_take;
			if (rd_take)
			begin
				avs_readdata <= rd_word;
			end
		end
	end

	// Flags and skip state.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			irq_global_enable <= 1'b0;
			ext0_req_flag <= 1'b0;
			ext1_req_flag <= 1'b0;
			skip_next <= 1'b0;
		end
		else
		begin
			irq_global_enable <= next_ie;
			ext0_req_flag <= next_req0;
			ext1_req_flag <= next_req1;
			skip_next <= next_skip;
		end
	end

	// Control bank and timer select; only the addressed slot changes.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctl_bank <= {8{ITC_NIB_RST}};
			timer_select_ctrl <= 1'b0;
		end
		else
		begin
			if (wr_go)
			begin
				ctl_bank[bank_ix] <= acc_in;
			end
			if (live & (op == ITC_WR_TSEL))
			begin
				timer_select_ctrl <= acc_in[0];
			end
		end
	end

	// Accumulator result. Carry is never reported, so it stays the core's.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			acc_value <= ITC_NIB_RST;
			acc_load <= 1'b0;
		end
		else
		begin
			acc_load <= rd_go;
			if (rd_go)
			begin
				acc_value <= ctl_bank[bank_ix];
			end
		end
	end

	// Checks on the executed instructions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	property p_mask;
		live && op == ITC_MASK_IRQ |=> !irq_global_enable;
	endproperty
	a_mask: assert property (p_mask) else $error("mask left enable set");

	property p_unmask;
		live && op == ITC_UNMASK_IRQ |=> irq_global_enable;
	endproperty
	a_unmask: assert property (p_unmask) else $error("unmask left enable clear");

	property p_req0_skip;
		live && op == ITC_TEST_REQ0 && !gate0 && ext0_req_flag && !ext0_req_set |=> skip_next && !ext0_req_flag;
	endproperty
	a_req0_skip: assert property (p_req0_skip) else $error("ext0 test did not skip");

	property p_req0_nop;
		live && op == ITC_TEST_REQ0 && gate0 |=> !skip_next && ext0_req_flag == $past(ext0_req_flag | ext0_req_set);
	endproperty
	a_req0_nop: assert property (p_req0_nop) else $error("gated ext0 test acted");

	property p_req1_skip;
		live && op == ITC_TEST_REQ1 && !gate1 && ext1_req_flag && !ext1_req_set |=> skip_next && !ext1_req_flag;
	endproperty
	a_req1_skip: assert property (p_req1_skip) else $error("ext1 test did not skip");

	property p_req1_nop;
		live && op == ITC_TEST_REQ1 && gate1 |=> !skip_next && ext1_req_flag == $past(ext1_req_flag | ext1_req_set);
	endproperty
	a_req1_nop: assert property (p_req1_nop) else $error("gated ext1 test acted");

	property p_lvl0;
		live && op == ITC_TEST_LVL0 |=> skip_next == $past(ext_irq_pin_zero == pol0);
	endproperty
	a_lvl0: assert property (p_lvl0) else $error("pin zero test wrong");

	property p_lvl1;
		live && op == ITC_TEST_LVL1 |=> skip_next == $past(ext_irq_pin_one == pol1);
	endproperty
	a_lvl1: assert property (p_lvl1) else $error("pin one test wrong");

	property p_rd;
		live && is_rd |=> acc_load && acc_value == $past(ctl_bank[bank_ix]);
	endproperty
	a_rd: assert property (p_rd) else $error("read transfer wrong");

	property p_wr;
		live && is_wr |=> ctl_bank[$past(bank_ix)] == $past(acc_in) && !acc_load;
	endproperty
	a_wr: assert property (p_wr) else $error("write transfer wrong");

	property p_tsel;
		live && op == ITC_WR_TSEL |=> timer_select_ctrl == $past(acc_in[0]) && !acc_load;
	endproperty
	a_tsel: assert property (p_tsel) else $error("timer select wrong");

	property p_swallow;
		exec_fire && skip_next |=> !skip_next && !acc_load && ctl_bank == $past(ctl_bank)
			&& irq_global_enable == $past(irq_global_enable);
	endproperty
	a_swallow: assert property (p_swallow) else $error("skipped op took effect");

	property p_bus;
		bus_take |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("waitrequest not one cycle");

endmodule // itc_exec

// ### dv/itc_pin_model.sv
/*
 * Model of the interrupt pins and request events beside the executor.
 * Assumes the bench commands pin levels and one-cycle event pulses on clk.
 */
`timescale 1ns/1ns
module itc_pin_model
(
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [1:0] lvl_cmd, // Wanted pin levels.
	input wire logic [1:0] pulse_cmd, // Wanted request events.
	output logic pin_zero, // Pin zero level.
	output logic pin_one, // Pin one level.
	output logic set0, // Request event zero.
	output logic set1 // Request event one.
);
	// Pins and events move only just after an edge, so the design sees clean synchronous inputs.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{pin_one, pin_zero} <= 2'h0;
			{set1, set0} <= 2'h0;
		end
		else
		begin
			{pin_one, pin_zero} <= lvl_cmd;
			{set1, set0} <= pulse_cmd;
		end
	end
endmodule // itc_pin_model

// ### dv/itc_exec_tb_top.sv
/*
 * Self-checking bench for the executor: register transfers, enable control and skip tests.
 * Assumes the pin model beside it and the one-cycle answer of the slave port.
 */
`timescale 1ns/1ns
module itc_exec_tb_top
	import itc_pkg::*;
;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest; // Clock, reset and bus strobes.
	logic [3:0] avs_address, acc_value, a, exp_w4; // Address, accumulator and expectations.
	logic [31:0] avs_writedata, avs_readdata, rd, seed; // Bus data and random state.
	logic pin_zero, pin_one, set0, set1, irq_global_enable, ext0_req_flag, ext1_req_flag; // Far side and flags.
	logic timer_select_ctrl, acc_load, skip_next; // Other design outputs.
	logic [1:0] lvl_cmd, pulse_cmd; // Commands to the pin model.
	itc_bank_t ctl_bank; // Control register bank.
	int bad_count, check_count, i, k, g, f; // Counters and loop indices.
	localparam logic [4:0] wr_op [0:7] = '{5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h11, 5'h13, 5'h15, 5'h17};
	localparam logic [4:0] rd_op [0:7] = '{5'h07, 5'h09, 5'h0B, 5'h0D, 5'h10, 5'h12, 5'h14, 5'h16};
	itc_pin_model pm (.clk(clk), .rst_n(rst_n), .lvl_cmd(lvl_cmd), .pulse_cmd(pulse_cmd), .pin_zero(pin_zero),
		.pin_one(pin_one), .set0(set0), .set1(set1));
	itc_exec dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_irq_pin_zero(pin_zero), .ext_irq_pin_one(pin_one), .ext0_req_set(set0), .ext1_req_set(set1),
		.irq_global_enable(irq_global_enable), .ext0_req_flag(ext0_req_flag), .ext1_req_flag(ext1_req_flag),
		.ctl_bank(ctl_bank), .timer_select_ctrl(timer_select_ctrl), .acc_value(acc_value), .acc_load(acc_load),
		.skip_next(skip_next));
	// Xorshift source; a fixed start keeps every run the same.
	function automatic logic [3:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[3:0];
	endfunction
	// A flag test skips only with its gate open and the flag raised.
	function automatic logic snz_exp(input logic gate, input logic flag);
		return !gate && flag;
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Compares one result; an unknown never matches.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	// One bus cycle, held until waitrequest is seen low; a stuck slave ends the run.
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
		int n;
		@(posedge clk);
		avs_address <= adr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= dat;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n == 20)
		begin
			bad_count++;
			finish_test();
		end
	endtask
	// Issues one instruction with its accumulator operand.
	task automatic exec(input logic [4:0] op, input logic [3:0] acc);
		bus(1'b1, 4'h0, {20'h0, acc, 3'h0, op}, rd);
	endtask
	// Free-running 250 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Main sequence.
	initial
	begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{lvl_cmd, pulse_cmd, bad_count, check_count} = '0;
		seed = 32'h00000061;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		cmp({31'h0, irq_global_enable}, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			a = xs();
			exec(wr_op[i], a);
			cmp({28'h0, ctl_bank[i]}, {28'h0, a});
			exec(rd_op[i], ~a);
			cmp({31'h0, acc_load}, 32'h1);
			cmp({28'h0, acc_value}, {28'h0, a});
			bus(1'b0, 4'h4, 32'h0, rd);
			cmp({28'h0, rd[3:0]}, {28'h0, a});
		end
		exp_w4 = a;
		for (i = 0; i < 2; i++)
		begin
			exec(5'h0F, {3'h5, i[0]});
			cmp({31'h0, timer_select_ctrl}, i);
		end
		bus(1'b0, 4'hC, 32'h0, rd);
		cmp(rd, 32'h0);
		$display("test transfers done");
		exec(5'h02, 4'h0);
		cmp({31'h0, irq_global_enable}, 32'h1);
		bus(1'b0, 4'h8, 32'h0, rd);
		cmp(rd, 32'h1);
		exec(5'h01, 4'h0);
		cmp({31'h0, irq_global_enable}, 32'h0);
		$display("test enable done");
		for (k = 0; k < 2; k++)
			for (g = 0; g < 2; g++)
				for (f = 0; f < 2; f++)
				begin
					exec(5'h08, {2'h0, g[0], g[0]});
					pulse_cmd[k] <= f[0];
					@(posedge clk);
					pulse_cmd <= 2'h0;
					repeat (3) @(posedge clk);
					exec(k ? 5'h04 : 5'h03, 4'h0);
					cmp({31'h0, skip_next}, snz_exp(g[0], f[0]));
					cmp({31'h0, k ? ext1_req_flag : ext0_req_flag}, f & g);
					a = xs();
					exec(5'h17, a);
					if (!snz_exp(g[0], f[0]))
						exp_w4 = a;
					cmp({28'h0, ctl_bank[7]}, {28'h0, exp_w4});
				end
		bus(1'b0, 4'h8, 32'h0, rd);
		cmp(rd, 32'h6);
		$display("test request skip done");
		for (k = 0; k < 2; k++)
			for (g = 0; g < 2; g++)
				for (f = 0; f < 2; f++)
				begin
					exec(k ? 5'h0E : 5'h0C, {1'b0, g[0], 2'h0});
					lvl_cmd <= {f[0], f[0]};
					repeat (3) @(posedge clk);
					exec(k ? 5'h06 : 5'h05, 4'h0);
					cmp({31'h0, skip_next}, g == f);
					exec(5'h00, 4'h0);
				end
		$display("test level skip done");
		finish_test();
	end
endmodule // itc_exec_tb_top
